// ---- tb.sv ----
// self-checking bench for the transmit clock generator and slot gate
`timescale 1ns/10ps
module tb;
  localparam int FRAME_EDGES = 384 * 4; // 384 slots of 4 bits
  // design signals, named as the ports
  logic        sys_clk, resetn, ce;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tx_word_data, rd;
  logic [3:0]  s_axi_wstrb, rx_nibble;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_word_valid, tx_word_ready;
  logic        tx_master_clock_in, tx_master_clock_out, tx_master_clock_oe;
  logic        tx_bit_clock_in, tx_bit_clock_out, tx_bit_clock_oe;
  logic        tx_data_out, tx_data_oe, ext_run;
  // bench counters
  int          edges, starts, fail_count, checks_done, m, b, s, k;
  int          divs[3] = '{0, 2, 4095};
  txhf_top #(.SLOT_BITS(4), .FIFO_DEPTH(32)) i_dut (.*);
  txhf_codec_model i_codec (.sys_clk(sys_clk), .run(ext_run), .bit_clk(tx_bit_clock_out),
    .data(tx_data_out), .data_oe(tx_data_oe), .mclk_pin(tx_master_clock_in),
    .bclk_pin(tx_bit_clock_in), .edges(edges), .starts(starts), .rx_nibble(rx_nibble));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  // one register read, then compare the data
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    check(rd, e);
  endtask
  // count master and bit clock toggles over a window
  task automatic toggles(input int cyc);
    logic pm;
    logic pb;
    m = 0;
    b = 0;
    repeat (cyc) begin
      pm = tx_master_clock_out;
      pb = tx_bit_clock_out;
      @(posedge sys_clk);
      m += int'(tx_master_clock_out != pm);
      b += int'(tx_bit_clock_out != pb);
    end
  endtask
  // set the slot mask, count active slot starts over one whole frame
  task automatic slots(input logic [31:0] mask);
    int e0;
    int s0;
    wr(txhf_pkg::OFF_SLOT_MASK, mask);
    e0 = edges + 8;
    while (edges < e0) @(posedge sys_clk);
    e0 = edges + FRAME_EDGES;
    s0 = starts;
    while (edges < e0) @(posedge sys_clk);
    s = starts - s0;
  endtask
  // verdict
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #800000;
    fail_count++;
    $display("CHECK FAILED at %0t: timeout", $time);
    complete_run;
  end
  initial begin
    {resetn, ext_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, tx_word_valid, s_axi_awaddr, s_axi_araddr} = '0;
    {fail_count, checks_done} = '0;
    ce           = 1'b1;
    s_axi_wdata  = '0;
    s_axi_wstrb  = 4'hF;
    tx_word_data = 32'hA000_0000;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values, reserved bits, unmapped offset
    rc(txhf_pkg::OFF_MCLK_CTL, 32'h0000_8000);
    rc(txhf_pkg::OFF_SLOT_MASK, 32'h0000_0000);
    wr(txhf_pkg::OFF_MCLK_CTL, 32'hFFFF_FFFF);
    rc(txhf_pkg::OFF_MCLK_CTL, 32'h0000_CFFF);
    wr(8'h40, 32'h1234_5678);
    check(32'(rsp), 32'(txhf_pkg::RESP_SLVERR));
    rc(8'h40, 32'h0000_0000);
    check(32'(rsp), 32'(txhf_pkg::RESP_SLVERR));
    $display("test registers done");
    // internal bit clock at divide-by-one follows the master clock
    wr(txhf_pkg::OFF_BCLK_CTL, 32'h0000_0020);
    // pin enable follows the register one edge later
    @(posedge sys_clk);
    check(32'(tx_bit_clock_oe), 32'h1);
    foreach (divs[i]) begin
      k = (divs[i] > 16) ? 2 : 8;
      wr(txhf_pkg::OFF_MCLK_CTL, 32'h0000_8000 | divs[i]);
      repeat (2 * (divs[i] + 1)) @(posedge sys_clk);
      toggles(k * (divs[i] + 1));
      check(m, k);
      check(b, k);
    end
    // master clock taken from the pin
    ext_run <= 1'b1;
    wr(txhf_pkg::OFF_MCLK_CTL, 32'h0000_0000);
    @(posedge sys_clk);
    check(32'(tx_master_clock_oe), 32'h0);
    repeat (12) @(posedge sys_clk);
    toggles(60);
    check(b, 20);
    $display("test clocks done");
    // fill the fifo until it refuses, then run the slots
    wr(txhf_pkg::OFF_MCLK_CTL, 32'h0000_8000);
    wr(txhf_pkg::OFF_BCLK_CTL, 32'h0000_0021);
    ext_run       <= 1'b0;
    tx_word_valid <= 1'b1;
    repeat (32) do @(posedge sys_clk); while (!tx_word_ready);
    tx_word_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(32'(tx_word_ready), 32'h0);
    wr(txhf_pkg::OFF_SER_CTL, 32'h0001_017F);
    slots(32'h8000_0000);
    check(s, 12);
    check(32'(rx_nibble), 32'hA);
    ce <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ce <= 1'b1;
    slots(32'h0000_0005);
    check(s, 24);
    check(32'(rx_nibble), 32'h0);
    check(32'(tx_word_ready), 32'h1);
    slots(32'h0000_0000);
    check(s, 0);
    $display("test slots done");
    complete_run;
  end
endmodule

// ---- txhf_codec_model.sv ----
// far-side converter: pin clocks and serial capture
`timescale 1ns/10ps
module txhf_codec_model (
  // clock and control
  input  wire logic  sys_clk,
  input  wire logic  run,
  // link from the device
  input  wire logic  bit_clk,
  input  wire logic  data,
  input  wire logic  data_oe,
  // pin clocks toward the device
  output logic       mclk_pin,
  output logic       bclk_pin,
  // observations
  output int         edges,
  output int         starts,
  output logic [3:0] rx_nibble
);
  logic bclk_q;  // last bit clock level
  logic oe_q;    // last enable level
  int   div_cnt; // pin clock divider
  initial begin
    {mclk_pin, bclk_q, oe_q, rx_nibble} = '0;
    {edges, starts, div_cnt} = '0;
  end
  // external bit clock is never framed here, so it stands still
  assign bclk_pin = 1'b0;
  // pin master clock toggles every 3 cycles, still while stopped
  always @(posedge sys_clk) begin
    div_cnt <= (div_cnt == 2) ? 0 : div_cnt + 1;
    if (!run) mclk_pin <= 1'b0;
    else if (div_cnt == 2) mclk_pin <= !mclk_pin;
  end
  // count bit edges and slot starts, sample data on falling bit clock
  always @(posedge sys_clk) begin
    bclk_q <= bit_clk;
    oe_q   <= data_oe;
    if (bit_clk && !bclk_q) edges <= edges + 1;
    if (data_oe && !oe_q) starts <= starts + 1;
    if (!bit_clk && bclk_q && data_oe) rx_nibble <= {rx_nibble[2:0], data};
  end
endmodule

// ---- txhf_fifo.sv ----
// word fifo between the user stream and the serializer
`timescale 1ns/10ps
module txhf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];      // storage
  logic [AW-1:0]    wr_ptr_reg;           // write index
  logic [AW-1:0]    rd_ptr_reg;           // read index
  logic [AW:0]      count_reg;            // words held
  logic [AW:0]      count_next;           // words after this cycle
  logic             push;                 // word taken in
  logic             pop;                  // word handed out

  assign push      = in_valid && in_ready;
  assign out_valid = (count_reg != '0);
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // occupancy after this cycle
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      // full stalls the source
      in_ready  <= (count_next != (AW+1)'(DEPTH));
    end
  end

  // storage write
  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ---- txhf_pkg.sv ----
// constants for the transmit master clock generator and slot gate
package txhf_pkg;
  // register byte offsets
  localparam logic [7:0]  OFF_MCLK_CTL   = 8'h00;  // tx_master_clock_control
  localparam logic [7:0]  OFF_SLOT_MASK  = 8'h04;  // tx_slot_enable_mask
  localparam logic [7:0]  OFF_BCLK_CTL   = 8'h08;  // tx_bit_clock_control
  localparam logic [7:0]  OFF_SER_CTL    = 8'h0C;  // serializer_control
  localparam logic [7:0]  OFF_STATUS     = 8'h10;  // slot number and underrun
  // master clock control fields
  localparam int          MCLK_SRC_BIT   = 15;
  localparam int          MCLK_INV_BIT   = 14;
  localparam int          MCLK_DIV_W     = 12;
  localparam logic [31:0] MCLK_CTL_MASK  = 32'h0000_CFFF;
  localparam logic [31:0] MCLK_CTL_RST   = 32'h0000_8000;
  // bit clock control fields
  localparam int          BCLK_SRC_BIT   = 5;
  localparam int          BCLK_DIV_W     = 5;
  localparam logic [31:0] BCLK_CTL_MASK  = 32'h0000_003F;
  localparam logic [31:0] BCLK_CTL_RST   = 32'h0000_0000;
  // serializer control fields
  localparam int          SER_EN_BIT     = 16;
  localparam int          SLOT_W         = 9;
  localparam logic [31:0] SER_CTL_MASK   = 32'h0001_01FF;
  localparam logic [31:0] SER_CTL_RST    = 32'h0000_001F;
  localparam logic [8:0]  SLOT_MAX_LAST  = 9'h17F;      // 384 slots
  // status field and slot mask reset value
  localparam int          UNDERRUN_BIT   = 16;
  localparam logic [31:0] SLOT_MASK_RST  = 32'h0000_0000;
  // bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ---- txhf_properties.sv ----
// port assertions for the transmit clock generator and slot gate
`timescale 1ns/10ps
module txhf_properties (
  // clock, reset, enable
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        ce,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // stream and pins
  input wire logic        tx_word_ready,
  input wire logic        tx_master_clock_out,
  input wire logic        tx_master_clock_oe,
  input wire logic        tx_data_out,
  input wire logic        tx_data_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  chk_wready_drops: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data ready held after transfer");
  chk_idle_line_low: assert property (!tx_data_oe |-> !tx_data_out)
    else $error("data driven in an inactive slot");
  chk_master_internal: assert property ($rose(resetn) |=> tx_master_clock_oe)
    else $error("master clock not internal after reset");
  chk_enable_freezes: assert property (!ce |=> $stable(tx_data_out) && $stable(tx_master_clock_out))
    else $error("state moved while enable low");
  // main scenarios
  cover property (s_axi_bvalid && s_axi_bresp == txhf_pkg::RESP_SLVERR);
  cover property ($rose(tx_data_oe));
  cover property (!tx_word_ready);
endmodule
bind txhf_top txhf_properties i_chk (.*);

// ---- txhf_top.sv ----
// transmit master clock generator, bit clock divider and tdm slot gate
`timescale 1ns/10ps
module txhf_top #(
  parameter int SLOT_BITS  = 32,
  parameter int FIFO_DEPTH = 32
) (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // transmit word stream
  input  wire logic [31:0] tx_word_data,
  input  wire logic        tx_word_valid,
  output logic             tx_word_ready,
  // master clock pin
  input  wire logic        tx_master_clock_in,
  output logic             tx_master_clock_out,
  output logic             tx_master_clock_oe,
  // bit clock pin
  input  wire logic        tx_bit_clock_in,
  output logic             tx_bit_clock_out,
  output logic             tx_bit_clock_oe,
  // serial data pin
  output logic             tx_data_out,
  output logic             tx_data_oe
);
  // divider widths, declared ahead of the counters that use them
  localparam int MCLK_DIV_W_L = txhf_pkg::MCLK_DIV_W;
  localparam int BCLK_DIV_W_L = txhf_pkg::BCLK_DIV_W;

  // registers
  logic [31:0]             mclk_ctl_reg;    // master clock control
  logic [31:0]             slot_mask_reg;   // slot enable mask
  logic [31:0]             bclk_ctl_reg;    // bit clock control
  logic [31:0]             ser_ctl_reg;     // serializer control
  logic                    underrun_reg;    // sticky: empty fifo in active slot
  // bus state
  logic                    aw_held_reg;     // address taken, write pending
  logic                    w_held_reg;      // data taken, write pending
  logic [7:0]              aw_addr_reg;     // held write address
  logic [31:0]             w_data_reg;      // held write data
  logic [3:0]              w_strb_reg;      // held byte strobes
  logic                    do_write;        // both halves present
  logic                    status_w1c;      // underrun clear request
  // pin synchronisers
  logic [1:0]              mpin_sync_reg;   // master clock pin
  logic [1:0]              bpin_sync_reg;   // bit clock pin
  // clock generation
  logic [MCLK_DIV_W_L-1:0] hdiv_cnt_reg;    // auxiliary divider count
  logic                    mint_lvl_reg;    // internal master clock level
  logic                    minv_prev_reg;   // last inverted master level
  logic [BCLK_DIV_W_L-1:0] bdiv_cnt_reg;    // bit clock divider count
  logic                    bint_lvl_reg;    // divided bit clock level
  logic                    bsel_prev_reg;   // last selected bit clock level
  logic                    m_sel;           // selected master clock
  logic                    m_inv;           // master clock after polarity
  logic                    m_edge;          // active master clock edge
  logic                    b_sel;           // selected bit clock
  logic                    b_edge;          // shift edge of bit clock
  // serializer
  logic [8:0]              slot_reg;        // current tdm slot
  logic [8:0]              slot_last;       // last slot, clamped to 383
  logic [$clog2(SLOT_BITS)-1:0] bit_idx_reg; // bit within slot
  logic [31:0]             shift_reg;       // outgoing word
  logic                    slot_start;      // first bit of a slot
  logic                    slot_active;     // mask and enable allow shifting
  logic                    fifo_valid;      // a word is waiting
  logic [31:0]             fifo_data;       // head word
  logic                    fifo_pop;        // take head word

  // merge a write under byte strobes and a writable-bit mask
  function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] val,
                                           input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    merge_wr = res & wmask;
  endfunction

  // true for offsets that hold a register
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == txhf_pkg::OFF_MCLK_CTL) || (addr == txhf_pkg::OFF_SLOT_MASK) ||
                (addr == txhf_pkg::OFF_BCLK_CTL) || (addr == txhf_pkg::OFF_SER_CTL) ||
                (addr == txhf_pkg::OFF_STATUS);
  endfunction

  assign do_write   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign status_w1c = do_write && (aw_addr_reg == txhf_pkg::OFF_STATUS) && w_strb_reg[2] &&
                      w_data_reg[txhf_pkg::UNDERRUN_BIT];

  // write address and data captured in either order
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= txhf_pkg::RESP_OKAY;
    end else if (ce) begin
      // address accepted
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      // data accepted
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      // response once both halves are in
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_reg) ? txhf_pkg::RESP_OKAY : txhf_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mclk_ctl_reg  <= txhf_pkg::MCLK_CTL_RST;
      slot_mask_reg <= txhf_pkg::SLOT_MASK_RST;
      bclk_ctl_reg  <= txhf_pkg::BCLK_CTL_RST;
      ser_ctl_reg   <= txhf_pkg::SER_CTL_RST;
    end else if (ce && do_write) begin
      case (aw_addr_reg)
        txhf_pkg::OFF_MCLK_CTL: begin
          mclk_ctl_reg <= merge_wr(mclk_ctl_reg, w_data_reg, w_strb_reg, txhf_pkg::MCLK_CTL_MASK);
        end
        txhf_pkg::OFF_SLOT_MASK: begin
          slot_mask_reg <= merge_wr(slot_mask_reg, w_data_reg, w_strb_reg, 32'hFFFF_FFFF);
        end
        txhf_pkg::OFF_BCLK_CTL: begin
          bclk_ctl_reg <= merge_wr(bclk_ctl_reg, w_data_reg, w_strb_reg, txhf_pkg::BCLK_CTL_MASK);
        end
        txhf_pkg::OFF_SER_CTL: begin
          ser_ctl_reg <= merge_wr(ser_ctl_reg, w_data_reg, w_strb_reg, txhf_pkg::SER_CTL_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // read channel: one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= txhf_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_mapped({s_axi_araddr[7:2], 2'b00}) ? txhf_pkg::RESP_OKAY
                                                              : txhf_pkg::RESP_SLVERR;
        case ({s_axi_araddr[7:2], 2'b00})
          txhf_pkg::OFF_MCLK_CTL:  s_axi_rdata <= mclk_ctl_reg;
          txhf_pkg::OFF_SLOT_MASK: s_axi_rdata <= slot_mask_reg;
          txhf_pkg::OFF_BCLK_CTL:  s_axi_rdata <= bclk_ctl_reg;
          txhf_pkg::OFF_SER_CTL:   s_axi_rdata <= ser_ctl_reg;
          txhf_pkg::OFF_STATUS:    s_axi_rdata <= {15'h0000, underrun_reg, 7'h00, slot_reg};
          default:                 s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // two-stage synchronisers for the clock pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mpin_sync_reg <= 2'b00;
      bpin_sync_reg <= 2'b00;
    end else if (ce) begin
      mpin_sync_reg <= {mpin_sync_reg[0], tx_master_clock_in};
      bpin_sync_reg <= {bpin_sync_reg[0], tx_bit_clock_in};
    end
  end

  // auxiliary clock divided by field plus one; level toggles each period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hdiv_cnt_reg <= '0;
      mint_lvl_reg <= 1'b0;
    end else if (ce) begin
      if (hdiv_cnt_reg >= mclk_ctl_reg[MCLK_DIV_W_L-1:0]) begin
        hdiv_cnt_reg <= '0;
        mint_lvl_reg <= !mint_lvl_reg;
      end else begin
        hdiv_cnt_reg <= hdiv_cnt_reg + 1'b1;
      end
    end
  end

  assign m_sel  = mclk_ctl_reg[txhf_pkg::MCLK_SRC_BIT] ? mint_lvl_reg : mpin_sync_reg[1];
  // polarity applied ahead of the bit clock divider
  assign m_inv  = m_sel ^ mclk_ctl_reg[txhf_pkg::MCLK_INV_BIT];
  assign m_edge = m_inv && !minv_prev_reg;

  // bit clock divider counts active master clock edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      minv_prev_reg <= 1'b0;
      bdiv_cnt_reg  <= '0;
      bint_lvl_reg  <= 1'b0;
    end else if (ce) begin
      minv_prev_reg <= m_inv;
      if (m_edge) begin
        if (bdiv_cnt_reg >= bclk_ctl_reg[BCLK_DIV_W_L-1:0]) begin
          bdiv_cnt_reg <= '0;
          bint_lvl_reg <= 1'b1;
        end else begin
          bdiv_cnt_reg <= bdiv_cnt_reg + 1'b1;
          // low for the second half of the period
          if (bdiv_cnt_reg + 1'b1 == BCLK_DIV_W_L'((32'(bclk_ctl_reg[BCLK_DIV_W_L-1:0]) + 1) / 2)) begin
            bint_lvl_reg <= 1'b0;
          end
        end
      end
    end
  end

  // clock pins driven from registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_master_clock_out <= 1'b0;
      tx_master_clock_oe  <= 1'b0;
      tx_bit_clock_out    <= 1'b0;
      tx_bit_clock_oe     <= 1'b0;
    end else if (ce) begin
      tx_master_clock_out <= mint_lvl_reg;
      tx_master_clock_oe  <= mclk_ctl_reg[txhf_pkg::MCLK_SRC_BIT];
      // divide-by-one passes the master clock straight out
      tx_bit_clock_out    <= (bclk_ctl_reg[BCLK_DIV_W_L-1:0] == '0) ? m_sel : bint_lvl_reg;
      tx_bit_clock_oe     <= bclk_ctl_reg[txhf_pkg::BCLK_SRC_BIT];
    end
  end

  // bit clock from pin or divider output
  assign b_sel  = bclk_ctl_reg[txhf_pkg::BCLK_SRC_BIT] ? tx_bit_clock_out : bpin_sync_reg[1];
  assign b_edge = b_sel && !bsel_prev_reg;

  assign slot_last   = (ser_ctl_reg[8:0] > txhf_pkg::SLOT_MAX_LAST) ? txhf_pkg::SLOT_MAX_LAST
                                                                     : ser_ctl_reg[8:0];
  assign slot_start  = b_edge && (bit_idx_reg == '0);
  assign slot_active = slot_mask_reg[slot_reg[4:0]] && ser_ctl_reg[txhf_pkg::SER_EN_BIT];
  assign fifo_pop    = slot_start && slot_active && fifo_valid;

  // slot and bit counters
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bsel_prev_reg <= 1'b0;
      bit_idx_reg   <= '0;
      slot_reg      <= 9'h000;
    end else if (ce) begin
      bsel_prev_reg <= b_sel;
      if (b_edge) begin
        if (bit_idx_reg == ($clog2(SLOT_BITS))'(SLOT_BITS-1)) begin
          bit_idx_reg <= '0;
          slot_reg    <= (slot_reg >= slot_last) ? 9'h000 : slot_reg + 1'b1;
        end else begin
          bit_idx_reg <= bit_idx_reg + 1'b1;
        end
      end
    end
  end

  // serializer: shifts msb first on each rising bit clock edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg   <= 32'h0000_0000;
      tx_data_out <= 1'b0;
      tx_data_oe  <= 1'b0;
    end else if (ce && b_edge) begin
      if (slot_start) begin
        if (slot_active) begin
          // active slot loads the next word
          shift_reg   <= fifo_valid ? {fifo_data[30:0], 1'b0} : 32'h0000_0000;
          tx_data_out <= fifo_valid ? fifo_data[31] : 1'b0;
          tx_data_oe  <= 1'b1;
        end else begin
          shift_reg   <= 32'h0000_0000;
          tx_data_out <= 1'b0;
          tx_data_oe  <= 1'b0;
        end
      end else begin
        shift_reg   <= {shift_reg[30:0], 1'b0};
        tx_data_out <= shift_reg[31];
      end
    end
  end

  // underrun sticky flag; a new event beats the clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      underrun_reg <= 1'b0;
    end else if (ce) begin
      if (slot_start && slot_active && !fifo_valid) begin
        underrun_reg <= 1'b1;
      end else if (status_w1c) begin
        underrun_reg <= 1'b0;
      end
    end
  end

  // word buffer ahead of the serializer
  txhf_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (tx_word_valid),
    .in_ready  (tx_word_ready),
    .in_data   (tx_word_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
endmodule
